// [rtl/ftl_channel.sv]
// start and critical hysteresis tracking for one temperature channel
// assumes a corrected quarter-degree temperature, valid every cycle
`timescale 1ns/10ps
`default_nettype none
module ftl_channel
    import ftl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic signed [11:0] i_temp_q,
    input wire ftl_chan_cfg_t i_cfg,
    output logic o_run,
    output logic o_crit,
    output logic o_over,
    output logic [11:0] o_excess_q
);
    logic signed [11:0] start_q;
    logic signed [11:0] limit_q;
    logic signed [11:0] hyst_q;
    logic above_start;
    logic start_release;
    logic crit_enable;
    logic crit_release;
    logic run_reg;
    logic run_next;
    logic crit_reg;
    logic crit_next;

    assign start_q = ftl_deg_to_q(i_cfg.start);
    assign limit_q = ftl_deg_to_q(i_cfg.limit);
    assign hyst_q = {6'h00, i_cfg.hyst, 2'b00};
    assign above_start = i_temp_q > start_q;
    assign start_release = i_temp_q <= start_q - hyst_q;
    assign crit_enable = i_cfg.limit != FTL_CRIT_DISABLE;
    assign o_over = crit_enable && (i_temp_q > limit_q);
    assign crit_release = i_temp_q < limit_q - hyst_q;

    assign run_next = above_start ? 1'b1 :
                      (start_release ? 1'b0 : run_reg);
    assign crit_next = !crit_enable ? 1'b0 :
                       (o_over ? 1'b1 :
                       (crit_release ? 1'b0 : crit_reg));
    // excess is zero at or below the start point
    assign o_excess_q = above_start ? 12'(i_temp_q - start_q) : 12'h000;
    assign o_run = run_reg;
    assign o_crit = crit_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run_reg <= 1'b0;
            crit_reg <= 1'b0;
        end else if (i_ce) begin
            run_reg <= run_next;
            crit_reg <= crit_next;
        end
    end
endmodule
`default_nettype wire

// [rtl/ftl_pwm.sv]
// pulse width generator for one fan drive output
// assumes duty changes at any time; a new value takes effect on the next clock, mid-period
`timescale 1ns/10ps
`default_nettype none
module ftl_pwm
    import ftl_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic [CNT_W-1:0] i_duty,
    output logic o_drive
);
    logic [CNT_W-1:0] cnt_reg;
    logic drive_next;
    logic drive_reg;

    // all ones means full drive, with no low slot in the period
    assign drive_next = (&i_duty) || (cnt_reg < i_duty);
    assign o_drive = drive_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= '0;
            drive_reg <= 1'b0;
        end else if (i_ce) begin
            cnt_reg <= cnt_reg + 1'b1;
            drive_reg <= drive_next;
        end
    end
endmodule
`default_nettype wire

// [rtl/ftl_top.sv]
// fan thermal limit register bank with automatic fan policy
// assumes an avalon-mm master and temperatures synchronous to i_clk
`timescale 1ns/10ps
`default_nettype none
module ftl_top
    import ftl_pkg::*;
#(
    parameter int PWM_W = 8
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic signed [9:0] i_temp_remote1,
    input wire logic signed [9:0] i_temp_local,
    input wire logic signed [9:0] i_temp_remote2,
    input wire logic i_overtemp_line_in,
    output logic o_overtemp_line_out,
    output logic o_overtemp_line_oe_n,
    output logic o_fan_drive_output_1,
    output logic o_fan_drive_output_2,
    output logic o_fan_drive_output_3,
    output logic o_xor_test_enable,
    output logic o_critical_active
);
    ftl_bus_state_t state_reg;
    ftl_bus_state_t state_next;
    logic [31:0] readdata_reg;
    logic [7:0] idx;
    logic aligned;
    logic wr_fire;
    logic rd_take;
    logic [7:0] wbyte;
    logic [7:0] rd_value;

    logic [7:0] min_duty_reg [3];
    logic [7:0] start_reg [3];
    logic [7:0] limit_reg [3];
    logic [3:0] hyst_reg [3];
    logic xor_en_reg;
    logic [7:0] off_remote1_reg;
    logic [7:0] off_local_reg;
    logic lock_reg;
    logic auto_reg;
    logic otpin_reg;
    logic [2:0] ramp_reg;

    logic locked_wr;
    logic min_wr_ok;
    logic signed [11:0] temp_q [3];
    ftl_chan_cfg_t chan_cfg [3];
    logic [2:0] run;
    logic [2:0] crit;
    logic [2:0] over;
    logic [11:0] excess_q [3];
    logic any_crit;
    logic any_over;
    logic [7:0] duty_next [3];
    logic [7:0] duty_reg [3];
    logic [2:0] drive;
    logic otl_drive_reg;

    // bus slave: one wait cycle, data registered for the answer cycle
    assign idx = i_avs_address[9:2];
    assign aligned = i_avs_address[1:0] == 2'b00;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) &&
                               (state_reg == FTL_BUS_IDLE);
    assign state_next = (state_reg == FTL_BUS_IDLE &&
                         (i_avs_read || i_avs_write)) ?
                        FTL_BUS_ACK : FTL_BUS_IDLE;
    assign wr_fire = i_ce && (state_reg == FTL_BUS_ACK) && i_avs_write &&
                     aligned && i_avs_byteenable[0];
    assign rd_take = i_ce && (state_reg == FTL_BUS_IDLE) && i_avs_read;
    assign wbyte = i_avs_writedata[7:0];
    assign o_avs_readdata = readdata_reg;

    // the lock bit itself can never be cleared short of reset
    assign locked_wr = wr_fire && !lock_reg;
    assign min_wr_ok = wr_fire && !auto_reg;

    always_comb begin
        rd_value = 8'h00;
        if (!aligned) begin
            rd_value = 8'h00;
        end else if (idx == FTL_IDX_MIN1) begin
            rd_value = min_duty_reg[0];
        end else if (idx == FTL_IDX_MIN2) begin
            rd_value = min_duty_reg[1];
        end else if (idx == FTL_IDX_MIN3) begin
            rd_value = min_duty_reg[2];
        end else if (idx == FTL_IDX_START1) begin
            rd_value = start_reg[0];
        end else if (idx == FTL_IDX_START2) begin
            rd_value = start_reg[1];
        end else if (idx == FTL_IDX_START3) begin
            rd_value = start_reg[2];
        end else if (idx == FTL_IDX_LIM1) begin
            rd_value = limit_reg[0];
        end else if (idx == FTL_IDX_LIM2) begin
            rd_value = limit_reg[1];
        end else if (idx == FTL_IDX_LIM3) begin
            rd_value = limit_reg[2];
        end else if (idx == FTL_IDX_HYST12) begin
            rd_value = {hyst_reg[0], hyst_reg[1]};
        end else if (idx == FTL_IDX_HYST3) begin
            rd_value = {hyst_reg[2], 4'h0};
        end else if (idx == FTL_IDX_XOR) begin
            rd_value = {7'h00, xor_en_reg};
        end else if (idx == FTL_IDX_OFF1) begin
            rd_value = off_remote1_reg;
        end else if (idx == FTL_IDX_OFF2) begin
            rd_value = off_local_reg;
        end else if (idx == FTL_IDX_CFG) begin
            rd_value = {5'h00, otpin_reg, auto_reg, lock_reg};
        end else if (idx == FTL_IDX_RAMP) begin
            rd_value = {5'h00, ramp_reg};
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= FTL_BUS_IDLE;
            readdata_reg <= 32'h0000_0000;
        end else if (i_ce) begin
            state_reg <= state_next;
            if (rd_take) begin
                readdata_reg <= {24'h00_0000, rd_value};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 3; i++) begin
                min_duty_reg[i] <= FTL_RST_MIN;
                start_reg[i] <= FTL_RST_START;
                limit_reg[i] <= FTL_RST_LIM;
            end
            hyst_reg[0] <= FTL_RST_HYST12[7:4];
            hyst_reg[1] <= FTL_RST_HYST12[3:0];
            hyst_reg[2] <= FTL_RST_HYST3;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (min_wr_ok && idx == FTL_IDX_MIN1 + 8'(i)) begin
                    min_duty_reg[i] <= wbyte;
                end
                if (locked_wr && idx == FTL_IDX_START1 + 8'(i)) begin
                    start_reg[i] <= wbyte;
                end
                if (locked_wr && idx == FTL_IDX_LIM1 + 8'(i)) begin
                    limit_reg[i] <= wbyte;
                end
            end
            if (wr_fire && idx == FTL_IDX_HYST12) begin
                hyst_reg[0] <= wbyte[7:4];
                hyst_reg[1] <= wbyte[3:0];
            end
            if (wr_fire && idx == FTL_IDX_HYST3) begin
                hyst_reg[2] <= wbyte[7:4];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            xor_en_reg <= 1'b0;
            off_remote1_reg <= FTL_RST_ZERO;
            off_local_reg <= FTL_RST_ZERO;
            lock_reg <= 1'b0;
            auto_reg <= 1'b0;
            otpin_reg <= 1'b0;
            ramp_reg <= FTL_RST_RAMP;
        end else begin
            if (locked_wr && idx == FTL_IDX_XOR) begin
                xor_en_reg <= wbyte[FTL_XOR_EN];
            end
            if (locked_wr && idx == FTL_IDX_OFF1) begin
                off_remote1_reg <= wbyte;
            end
            if (locked_wr && idx == FTL_IDX_OFF2) begin
                off_local_reg <= wbyte;
            end
            if (wr_fire && idx == FTL_IDX_CFG) begin
                lock_reg <= lock_reg || wbyte[FTL_CFG_LOCK];
                auto_reg <= wbyte[FTL_CFG_AUTO];
                otpin_reg <= wbyte[FTL_CFG_OTPIN];
            end
            if (wr_fire && idx == FTL_IDX_RAMP) begin
                ramp_reg <= wbyte[2:0];
            end
        end
    end

    // offsets are quarter degrees, the same unit as the readings
    assign temp_q[0] = {{2{i_temp_remote1[9]}}, i_temp_remote1} +
                       {{4{off_remote1_reg[7]}}, off_remote1_reg};
    assign temp_q[1] = {{2{i_temp_local[9]}}, i_temp_local} +
                       {{4{off_local_reg[7]}}, off_local_reg};
    assign temp_q[2] = {{2{i_temp_remote2[9]}}, i_temp_remote2};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_chan
            assign chan_cfg[g] = '{start: start_reg[g],
                                   limit: limit_reg[g],
                                   hyst: hyst_reg[g]};
            ftl_channel u_chan (
                .i_clk(i_clk),
                .i_reset_n(i_reset_n),
                .i_ce(i_ce),
                .i_temp_q(temp_q[g]),
                .i_cfg(chan_cfg[g]),
                .o_run(run[g]),
                .o_crit(crit[g]),
                .o_over(over[g]),
                .o_excess_q(excess_q[g])
            );
            // manual mode drives the software minimum duty directly unless a channel is critical
            assign duty_next[g] = any_crit ? FTL_FULL_DUTY :
                (!auto_reg ? min_duty_reg[g] :
                (run[g] ? ftl_ramp_duty(min_duty_reg[g], excess_q[g],
                                        ramp_reg) :
                 FTL_OFF_DUTY));
            ftl_pwm #(
                .CNT_W(PWM_W)
            ) u_pwm (
                .i_clk(i_clk),
                .i_reset_n(i_reset_n),
                .i_ce(i_ce),
                .i_duty(duty_reg[g]),
                .o_drive(drive[g])
            );
        end
    endgenerate

    assign any_crit = |crit;
    assign any_over = |over;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 3; i++) begin
                duty_reg[i] <= FTL_OFF_DUTY;
            end
            otl_drive_reg <= 1'b0;
        end else if (i_ce) begin
            for (int i = 0; i < 3; i++) begin
                duty_reg[i] <= duty_next[i];
            end
            otl_drive_reg <= otpin_reg && any_over;
        end
    end

    // open drain: only ever pulls low, the line input is not used here
    assign o_overtemp_line_out = 1'b0;
    assign o_overtemp_line_oe_n = !otl_drive_reg;
    assign o_fan_drive_output_1 = drive[0];
    assign o_fan_drive_output_2 = drive[1];
    assign o_fan_drive_output_3 = drive[2];
    assign o_xor_test_enable = xor_en_reg;
    assign o_critical_active = any_crit;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence wr_to_s(logic [7:0] target);
        wr_fire && idx == target;
    endsequence

    min_auto_lock_a: assert property (
        (wr_to_s(FTL_IDX_MIN1) and auto_reg) |=> $stable(min_duty_reg[0]))
        else $error("min duty changed in automatic mode");
    start_lock_a: assert property (
        (wr_to_s(FTL_IDX_START2) and lock_reg) |=> $stable(start_reg[1]))
        else $error("start temp changed while locked");
    crit_lock_a: assert property (
        (wr_to_s(FTL_IDX_LIM3) and lock_reg) |=> $stable(limit_reg[2]))
        else $error("critical limit changed while locked");
    offset_lock_a: assert property (
        (wr_to_s(FTL_IDX_OFF2) and lock_reg) |=> $stable(off_local_reg))
        else $error("offset changed while locked");
    xor_write_a: assert property (
        (wr_to_s(FTL_IDX_XOR) and !lock_reg) |=>
        o_xor_test_enable == $past(wbyte[0]))
        else $error("xor test enable not taken");
    full_drive_a: assert property (
        (any_crit && i_ce) |=> duty_reg[0] == FTL_FULL_DUTY &&
        duty_reg[1] == FTL_FULL_DUTY && duty_reg[2] == FTL_FULL_DUTY)
        else $error("critical state without full duty");
    crit_disable_a: assert property (
        (limit_reg[1] == FTL_CRIT_DISABLE && i_ce) |=> !crit[1])
        else $error("disabled limit still forced full drive");
    crit_hold_a: assert property (
        (crit[0] && i_ce && limit_reg[0] != FTL_CRIT_DISABLE &&
         temp_q[0] >= ftl_deg_to_q(limit_reg[0]) -
                      $signed({6'h00, hyst_reg[0], 2'b00})) |=> crit[0])
        else $error("critical released above limit minus hysteresis");
    start_hold_a: assert property (
        (run[1] && i_ce && temp_q[1] > ftl_deg_to_q(start_reg[1]) -
                 $signed({6'h00, hyst_reg[1], 2'b00})) |=> run[1])
        else $error("fan stopped above start minus hysteresis");
    ramp_floor_a: assert property (
        (auto_reg && run[2] && !any_crit && i_ce) ##1
        ($stable(min_duty_reg[2]) && $stable(auto_reg)) |->
        duty_reg[2] >= min_duty_reg[2])
        else $error("running fan below minimum duty");
    overtemp_pin_a: assert property (
        (otpin_reg && any_over && i_ce) |=> !o_overtemp_line_oe_n)
        else $error("overtemp line not pulled low");
endmodule
`default_nettype wire

// [shared/ftl_pkg.sv]
// constants, types and helpers for the fan thermal limit register bank
// assumes quarter-degree signed temperatures arrive from the sensor side
package ftl_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] FTL_IDX_MIN1 = 8'h64;
    localparam logic [7:0] FTL_IDX_MIN2 = 8'h65;
    localparam logic [7:0] FTL_IDX_MIN3 = 8'h66;
    localparam logic [7:0] FTL_IDX_START1 = 8'h67;
    localparam logic [7:0] FTL_IDX_START2 = 8'h68;
    localparam logic [7:0] FTL_IDX_START3 = 8'h69;
    localparam logic [7:0] FTL_IDX_LIM1 = 8'h6A;
    localparam logic [7:0] FTL_IDX_LIM2 = 8'h6B;
    localparam logic [7:0] FTL_IDX_LIM3 = 8'h6C;
    localparam logic [7:0] FTL_IDX_HYST12 = 8'h6D;
    localparam logic [7:0] FTL_IDX_HYST3 = 8'h6E;
    localparam logic [7:0] FTL_IDX_XOR = 8'h6F;
    localparam logic [7:0] FTL_IDX_OFF1 = 8'h70;
    localparam logic [7:0] FTL_IDX_OFF2 = 8'h71;
    localparam logic [7:0] FTL_IDX_CFG = 8'h40;
    localparam logic [7:0] FTL_IDX_RAMP = 8'h41;
    // reset values
    localparam logic [7:0] FTL_RST_MIN = 8'h80;
    localparam logic [7:0] FTL_RST_START = 8'h5A;
    localparam logic [7:0] FTL_RST_LIM = 8'h64;
    localparam logic [7:0] FTL_RST_HYST12 = 8'h44;
    localparam logic [3:0] FTL_RST_HYST3 = 4'h4;
    localparam logic [7:0] FTL_RST_ZERO = 8'h00;
    localparam logic [2:0] FTL_RST_RAMP = 3'h4;
    // field positions
    localparam int FTL_CFG_LOCK = 0;
    localparam int FTL_CFG_AUTO = 1;
    localparam int FTL_CFG_OTPIN = 2;
    localparam int FTL_XOR_EN = 0;
    // special values
    localparam logic [7:0] FTL_FULL_DUTY = 8'hFF;
    localparam logic [7:0] FTL_OFF_DUTY = 8'h00;
    localparam logic [7:0] FTL_CRIT_DISABLE = 8'h80;

    typedef enum logic {
        FTL_BUS_IDLE = 1'b0,
        FTL_BUS_ACK = 1'b1
    } ftl_bus_state_t;

    typedef struct packed {
        logic [7:0] start;
        logic [7:0] limit;
        logic [3:0] hyst;
    } ftl_chan_cfg_t;

    // whole degrees to signed quarter degrees
    function automatic logic signed [11:0] ftl_deg_to_q(
        input logic [7:0] deg);
        ftl_deg_to_q = {{2{deg[7]}}, deg, 2'b00};
    endfunction

    // linear ramp from minimum duty to full over 2^(code+1) degrees
    function automatic logic [7:0] ftl_ramp_duty(
        input logic [7:0] min_duty,
        input logic [11:0] excess_q,
        input logic [2:0] code);
        logic [19:0] prod;
        logic [19:0] inc;
        logic [7:0] room;
        room = FTL_FULL_DUTY - min_duty;
        prod = {12'h000, room} * {8'h00, excess_q};
        inc = prod >> ({2'b00, code} + 5'd3);
        if (inc >= {12'h000, room}) begin
            ftl_ramp_duty = FTL_FULL_DUTY;
        end else begin
            ftl_ramp_duty = min_duty + inc[7:0];
        end
    endfunction
endpackage

// [verif/fan_thermal_limit_regs_bench.sv]
// self-checking bench for the fan thermal limit register bank
// assumes ftl_pkg and the fan drive model are compiled first
`timescale 1ns/10ps
`default_nettype none
module fan_thermal_limit_regs_bench;
    import ftl_pkg::*;
    logic i_clk, i_reset_n, rd, wr, clr, en, wq, oe_n, ot_out, xor_test_enable, crit;
    logic [9:0] addr;
    logic [31:0] wdata, rdata, got;
    logic signed [9:0] t1, tl, t2;
    logic [2:0] fan;
    logic [2:0][8:0] hi;
    int bad_count, check_count;
    // open-drain line with a pull-up
    wire logic line = oe_n ? 1'b1 : ot_out;
    logic [7:0] rst_tab [14] = '{8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A,
        8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00};
    ftl_top u_ftl_top (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'h1),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
        .i_temp_remote1(t1), .i_temp_local(tl), .i_temp_remote2(t2),
        .i_overtemp_line_in(line), .o_overtemp_line_out(ot_out),
        .o_overtemp_line_oe_n(oe_n), .o_fan_drive_output_1(fan[0]),
        .o_fan_drive_output_2(fan[1]), .o_fan_drive_output_3(fan[2]),
        .o_xor_test_enable(xor_test_enable), .o_critical_active(crit));
    ftl_fan_model u_ftl_fan_model (.i_clk(i_clk), .i_clear(clr), .i_en(en),
        .i_drive(fan), .o_high(hi));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic give_verdict();
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // request held until waitrequest is sampled low
    task automatic bus(input logic wt, input logic [7:0] i,
        input logic [7:0] d);
        int n;
        n = 0;
        addr <= {i, 2'b00};
        wr <= wt;
        rd <= !wt;
        wdata <= {24'h00_0000, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (wq !== 1'b0 && n < 40);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (wq !== 1'b0) begin
            chk(32'h0000_0000, 32'h0000_0001);
            give_verdict();
        end
        @(posedge i_clk);
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        chk(got, {24'h00_0000, e});
    endtask
    // one full pwm period per window, after the old period drains
    task automatic meas(input logic [8:0] e);
        w(260);
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
        en <= 1'b1;
        w(256);
        en <= 1'b0;
        @(posedge i_clk);
        for (int k = 0; k < 3; k++) chk({23'h00_0000, hi[k]}, {23'h0, e});
    endtask
    task automatic tmp(input logic signed [9:0] q);
        t1 <= q;
        tl <= q;
        t2 <= q;
    endtask
    task automatic t_regs();
        for (int k = 0; k < 14; k++) rc(8'h64 + k[7:0], rst_tab[k]);
        rc(8'h50, 8'h00);
    endtask
    task automatic t_xor();
        bus(1'b1, 8'h6F, 8'h01);
        chk({31'h0, xor_test_enable}, 32'h0000_0001);
        rc(8'h6F, 8'h01);
        bus(1'b1, 8'h6F, 8'h00);
        chk({31'h0, xor_test_enable}, 32'h0000_0000);
    endtask
    task automatic t_duty();
        logic [7:0] v [4] = '{8'h00, 8'hFF, 8'h40, 8'h80};
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 3; j++) bus(1'b1, 8'h64 + j[7:0], v[k]);
            meas(v[k] == 8'hFF ? 9'h100 : {1'b0, v[k]});
        end
    endtask
    task automatic t_auto();
        bus(1'b1, 8'h40, 8'h02);
        bus(1'b1, 8'h64, 8'h33);
        rc(8'h64, 8'h80);
        for (int j = 0; j < 3; j++) bus(1'b1, 8'h67 + j[7:0], 8'h28);
        tmp(10'sd120);
        meas(9'h000);
        tmp(10'sd161);
        meas(9'h080);
        tmp(10'sd192);
        meas(9'h09F);
        bus(1'b1, 8'h41, 8'h03);
        meas(9'h0BF);
        bus(1'b1, 8'h41, 8'h04);
        tmp(10'sd152);
        meas(9'h080);
        tmp(10'sd140);
        meas(9'h000);
    endtask
    task automatic t_crit();
        bus(1'b1, 8'h40, 8'h04);
        bus(1'b1, 8'h6B, 8'h32);
        tl <= 10'sd204;
        meas(9'h100);
        chk({31'h0, crit}, 32'h0000_0001);
        chk({31'h0, line}, 32'h0000_0000);
        tl <= 10'sd188;
        meas(9'h100);
        tl <= 10'sd180;
        meas(9'h080);
        chk({31'h0, line}, 32'h0000_0001);
        bus(1'b1, 8'h6B, 8'h80);
        tl <= 10'sd400;
        meas(9'h080);
        bus(1'b1, 8'h6D, 8'h4F);
        bus(1'b1, 8'h6B, 8'h32);
        tl <= 10'sd140;
        w(4);
        chk({31'h0, crit}, 32'h0000_0001);
        tl <= 10'sd136;
        w(4);
        chk({31'h0, crit}, 32'h0000_0000);
        bus(1'b1, 8'h6D, 8'h44);
    endtask
    task automatic t_offset();
        bus(1'b1, 8'h6A, 8'h32);
        bus(1'b1, 8'h71, 8'hF8);
        t1 <= 10'sd80;
        tl <= 10'sd204;
        w(4);
        chk({31'h0, crit}, 32'h0000_0000);
        bus(1'b1, 8'h71, 8'h00);
        w(4);
        chk({31'h0, crit}, 32'h0000_0001);
        tl <= 10'sd80;
        w(4);
        bus(1'b1, 8'h70, 8'h04);
        t1 <= 10'sd198;
        w(4);
        chk({31'h0, crit}, 32'h0000_0001);
    endtask
    task automatic t_lock();
        logic [7:0] li [4] = '{8'h68, 8'h6C, 8'h6F, 8'h71};
        logic [7:0] le [4] = '{8'h28, 8'h64, 8'h00, 8'h00};
        bus(1'b1, 8'h40, 8'h01);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, li[k], 8'h01);
            rc(li[k], le[k]);
        end
    endtask
    initial begin
        i_reset_n = 1'b0;
        {rd, wr, clr, en} = 4'h0;
        addr = 10'h000;
        wdata = 32'h0000_0000;
        tmp(10'sd80);
        w(12);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        t_regs();
        t_xor();
        t_duty();
        t_auto();
        t_crit();
        t_offset();
        t_lock();
        give_verdict();
    end
endmodule
`default_nettype wire

// [verif/ftl_fan_model.sv]
// fan drive model: integrates drive-high cycles per output in a window
// assumes the bench opens and clears the window on rising edges
`timescale 1ns/10ps
`default_nettype none
module ftl_fan_model (
    input wire logic i_clk,
    input wire logic i_clear,
    input wire logic i_en,
    input wire logic [2:0] i_drive,
    output logic [2:0][8:0] o_high
);
    // a fan only sees average drive, so the count stands for its speed
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 3; k++) begin
            if (i_clear) begin
                o_high[k] <= 9'h000;
            end else if (i_en) begin
                o_high[k] <= o_high[k] + {8'h00, i_drive[k]};
            end
        end
    end
endmodule
`default_nettype wire
